// ### arpc_map.svh
// constants for the audio recorder/player controller
// assumes inclusion by bare name from design files
`ifndef ARPC_MAP_SVH
`define ARPC_MAP_SVH
`define ARPC_SAMPLE_BITS 16
`define ARPC_FIFO_DEPTH 16
`define ARPC_CLK_PERIOD_PS 5000
`define ARPC_DEBOUNCE_US 10
`define ARPC_DEBOUNCE_CYCLES ((`ARPC_DEBOUNCE_US * 1000000) / `ARPC_CLK_PERIOD_PS)
`define ARPC_RATE_96K 3'h0
`define ARPC_RATE_48K 3'h1
`define ARPC_RATE_44K1 3'h2
`define ARPC_RATE_32K 3'h3
`define ARPC_RATE_8K 3'h4
`define ARPC_SRC_MIC 1'h0
`define ARPC_SRC_LINE 1'h1
`endif

// ### arpc_pkg.sv
// types shared by the audio recorder/player controller
// assumes arpc_map.svh is on the include path
`include "arpc_map.svh"
package arpc_pkg;
  typedef enum logic [2:0] {
    arpc_rate_96k_type_v,
    arpc_rate_48k_type_v,
    arpc_rate_44k1_type_v,
    arpc_rate_32k_type_v,
    arpc_rate_8k_type_v
  } arpc_rate_type;
  typedef struct packed {
    logic [`ARPC_SAMPLE_BITS-1:0] left;
    logic [`ARPC_SAMPLE_BITS-1:0] right;
  } arpc_frame_type;
endpackage

// ### arpc_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module arpc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  // honest full and empty from the occupancy count
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
  // pointers wrap because depth is a power of two
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end
endmodule

// ### arpc_debounce.sv
// push-button synchroniser, debouncer and press detector
// assumes an active-low asynchronous button pin
`timescale 1ns/1ps
`include "arpc_map.svh"
module arpc_debounce (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic button_n,
  output logic press
);
  localparam int CW = $clog2(`ARPC_DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(`ARPC_DEBOUNCE_CYCLES);
  logic sync1_r;
  logic sync2_r;
  logic stable_r;
  logic [CW-1:0] cnt_r;
  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_r <= 1'h1;
      sync2_r <= 1'h1;
    end else begin
      sync1_r <= button_n;
      sync2_r <= sync1_r;
    end
  end
  // accept a new level only after it held for the full window
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stable_r <= 1'h1;
      cnt_r <= '0;
      press <= 1'h0;
    end else begin
      press <= 1'h0;
      if (sync2_r == stable_r) begin
        cnt_r <= '0;
      end else if (cnt_r == LIMIT) begin
        cnt_r <= '0;
        stable_r <= sync2_r;
        press <= !sync2_r;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// ### arpc_top.sv
// audio recorder/player control: buttons, switches, i2s slave and buffers
// assumes codec is i2s master; store side is a processor audio buffer
// Overview of operation
// - the source switch low picks microphone, high picks line input.
// - rate switches decode 000 96K, 001 48K, 010 44.1K, 011 32K, 100 8K, else 96K.
// - each record press starts recording when idle and stops it when running.
// - each play press starts playback when idle and stops it when running.
// - recording ends by itself once the store has no free space.
// - playback ends by itself after the last stored sample went to the codec.
// - the serial link carries i2s frames of 16-bit sample words.
// - the codec drives bit and frame clocks and this block follows them both ways.
// - the 18.432MHz pll clock is passed straight to the codec master clock pin.
// - the codec i2c clock and data are plain software-driven i/o lines.
// - the block sends playback samples and receives recorded samples on the link.
`timescale 1ns/1ps
`include "arpc_map.svh"
module arpc_top
  import arpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic source_select_switch,
  input wire logic rate_select_bit2,
  input wire logic rate_select_bit1,
  input wire logic rate_select_bit0,
  input wire logic record_button_n,
  input wire logic play_button_n,
  input wire logic pll_clk,
  output logic codec_master_clock_pin,
  input wire logic codec_bit_clock,
  input wire logic codec_frame_clock,
  input wire logic codec_adc_data,
  output logic codec_dac_data,
  input wire logic i2c_clock_out,
  input wire logic i2c_clock_oe,
  output logic i2c_clock_in,
  input wire logic i2c_data_out,
  input wire logic i2c_data_oe,
  output logic i2c_data_in,
  input wire logic codec_i2c_clock_in,
  output logic codec_i2c_clock_out,
  output logic codec_i2c_clock_oe,
  input wire logic codec_i2c_data_in,
  output logic codec_i2c_data_out,
  output logic codec_i2c_data_oe,
  output logic line_input_select,
  output arpc_pkg::arpc_rate_type sample_rate,
  output logic recording,
  output logic playing,
  input wire logic store_full,
  output arpc_pkg::arpc_frame_type rec_data,
  output logic rec_valid,
  input wire logic rec_ready,
  input wire logic play_last,
  input wire arpc_pkg::arpc_frame_type play_data,
  input wire logic play_valid,
  output logic play_ready
);
  import arpc_pkg::*;
  localparam int SW = `ARPC_SAMPLE_BITS;
  logic rec_press;
  logic play_press;
  logic recording_r;
  logic playing_r;
  logic last_pending_r;
  logic [2:0] bclk_sync_r;
  logic [2:0] lrck_sync_r;
  logic [1:0] adc_sync_r;
  logic bclk_rise;
  logic bclk_fall;
  logic lrck_prev_r;
  logic lrck_edge;
  logic [4:0] bit_cnt_r;
  logic [SW-1:0] rx_shift_r;
  logic [SW-1:0] rx_left_r;
  logic [SW-1:0] tx_shift_r;
  arpc_frame_type tx_frame_r;
  arpc_frame_type rx_frame_r;
  logic rx_push_r;
  logic tx_out_valid;
  logic rx_in_ready;
  arpc_frame_type tx_head;
  logic tx_pop;
  logic [2:0] rate_bits;
  logic [3:0] sw_meta_r;
  logic [3:0] sw_sync_r;
  logic [1:0] i2c_meta_r;
  logic [1:0] i2c_sync_r;
  logic play_fifo_ready;
  logic play_open;

  // master clock is a pure pass-through; no logic touches it
  assign codec_master_clock_pin = pll_clk;

  // i2c lines are bare gpio; software bit-bangs the codec config
  assign codec_i2c_clock_out = i2c_clock_out;
  assign codec_i2c_clock_oe = i2c_clock_oe;
  assign codec_i2c_data_out = i2c_data_out;
  assign codec_i2c_data_oe = i2c_data_oe;

  // returning pin levels are foreign; two flops before software reads them
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      i2c_meta_r <= 2'h0;
      i2c_sync_r <= 2'h0;
    end else begin
      i2c_meta_r <= {codec_i2c_clock_in, codec_i2c_data_in};
      i2c_sync_r <= i2c_meta_r;
    end
  end
  assign i2c_clock_in = i2c_sync_r[1];
  assign i2c_data_in = i2c_sync_r[0];

  // slide switches are foreign pins: two flops before the decode reads them
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sw_meta_r <= 4'h0;
      sw_sync_r <= 4'h0;
    end else begin
      sw_meta_r <= {rate_select_bit2, rate_select_bit1, rate_select_bit0, source_select_switch};
      sw_sync_r <= sw_meta_r;
    end
  end

  // source selection and rate decode, registered so outputs come from flops
  assign rate_bits = sw_sync_r[3:1];
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      line_input_select <= 1'h0;
      sample_rate <= arpc_rate_96k_type_v;
    end else begin
      line_input_select <= (sw_sync_r[0] == `ARPC_SRC_LINE);
      case (rate_bits)
        `ARPC_RATE_96K: sample_rate <= arpc_rate_96k_type_v;
        `ARPC_RATE_48K: sample_rate <= arpc_rate_48k_type_v;
        `ARPC_RATE_44K1: sample_rate <= arpc_rate_44k1_type_v;
        `ARPC_RATE_32K: sample_rate <= arpc_rate_32k_type_v;
        `ARPC_RATE_8K: sample_rate <= arpc_rate_8k_type_v;
        default: sample_rate <= arpc_rate_96k_type_v;
      endcase
    end
  end

  // button cleaning, one pulse per press
  arpc_debounce u_rec_btn (
    .ref_clk(ref_clk),
    .reset(reset),
    .button_n(record_button_n),
    .press(rec_press)
  );
  arpc_debounce u_play_btn (
    .ref_clk(ref_clk),
    .reset(reset),
    .button_n(play_button_n),
    .press(play_press)
  );

  // record state: press toggles, a full store ends it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      recording_r <= 1'h0;
    end else if (recording_r && store_full) begin
      recording_r <= 1'h0;
    end else if (rec_press) begin
      recording_r <= !recording_r;
    end
  end

  // play state: press toggles, the last sample leaving the link ends it
  // the stop waits for the left-start edge after the buffer ran dry, so the final right word is out
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      playing_r <= 1'h0;
      last_pending_r <= 1'h0;
    end else begin
      if (play_press) begin
        playing_r <= !playing_r;
        last_pending_r <= 1'h0;
      end else if (playing_r && play_valid && play_ready && play_last) begin
        last_pending_r <= 1'h1;
      end else if (last_pending_r && !tx_out_valid && lrck_edge && !lrck_sync_r[1]) begin
        playing_r <= 1'h0;
        last_pending_r <= 1'h0;
      end
    end
  end
  assign recording = recording_r;
  assign playing = playing_r;

  // link clocks are foreign: two flops, then a third for edge finding
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bclk_sync_r <= 3'h0;
      lrck_sync_r <= 3'h0;
      adc_sync_r <= 2'h0;
    end else begin
      bclk_sync_r <= {bclk_sync_r[1:0], codec_bit_clock};
      lrck_sync_r <= {lrck_sync_r[1:0], codec_frame_clock};
      adc_sync_r <= {adc_sync_r[0], codec_adc_data};
    end
  end
  assign bclk_rise = bclk_sync_r[1] && !bclk_sync_r[2];
  assign bclk_fall = !bclk_sync_r[1] && bclk_sync_r[2];

  // frame edge seen at the bit clock rise that samples the new frame level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lrck_prev_r <= 1'h0;
    end else if (bclk_rise) begin
      lrck_prev_r <= lrck_sync_r[1];
    end
  end
  assign lrck_edge = bclk_rise && (lrck_sync_r[1] != lrck_prev_r);

  // receive: msb arrives on the rise after the frame edge; the lsb lands on the
  // rise that shows the next frame edge, so the capture is tested before the count restarts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bit_cnt_r <= 5'h0;
      rx_shift_r <= '0;
      rx_left_r <= '0;
      rx_frame_r <= '0;
      rx_push_r <= 1'h0;
    end else begin
      rx_push_r <= 1'h0;
      if (bclk_rise && bit_cnt_r == 5'(SW-1)) begin
        // the word belongs to the frame level seen before this rise
        if (!lrck_prev_r) begin
          rx_left_r <= {rx_shift_r[SW-2:0], adc_sync_r[1]};
        end else begin
          rx_frame_r <= '{left: rx_left_r, right: {rx_shift_r[SW-2:0], adc_sync_r[1]}};
          rx_push_r <= recording_r;
        end
      end
      if (lrck_edge) begin
        bit_cnt_r <= 5'h0;
      end else if (bclk_rise && bit_cnt_r != 5'(SW)) begin
        rx_shift_r <= {rx_shift_r[SW-2:0], adc_sync_r[1]};
        bit_cnt_r <= bit_cnt_r + 5'h1;
      end
    end
  end

  // record path buffer; a stalled store drops frames rather than the link
  arpc_fifo #(.WIDTH(2*SW), .DEPTH(`ARPC_FIFO_DEPTH)) u_rec_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_data(rx_frame_r),
    .in_valid(rx_push_r),
    .in_ready(rx_in_ready),
    .out_data(rec_data),
    .out_valid(rec_valid),
    .out_ready(rec_ready)
  );

  // playback buffer; its ready stalls the store side
  arpc_fifo #(.WIDTH(2*SW), .DEPTH(`ARPC_FIFO_DEPTH)) u_play_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_data(play_data),
    .in_valid(play_valid && play_open),
    .in_ready(play_fifo_ready),
    .out_data(tx_head),
    .out_valid(tx_out_valid),
    .out_ready(tx_pop)
  );

  // the store sees ready only while frames are really accepted
  assign play_open = playing_r && !last_pending_r;
  assign play_ready = play_fifo_ready && play_open;

  // a frame is taken from the buffer at each left-channel start while the buffer holds one
  assign tx_pop = lrck_edge && !lrck_sync_r[1] && tx_out_valid;

  // transmit: load on frame edge, first bit driven at the next fall
  // the synced fall lags about three system clocks, well inside half a bit period
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_frame_r <= '0;
      tx_shift_r <= '0;
      codec_dac_data <= 1'h0;
    end else begin
      if (lrck_edge) begin
        if (!lrck_sync_r[1]) begin
          tx_frame_r <= tx_pop ? tx_head : '0; // silence on underrun
          tx_shift_r <= tx_pop ? tx_head.left : '0;
        end else begin
          tx_shift_r <= tx_frame_r.right;
        end
      end else if (bclk_fall && bit_cnt_r < 5'(SW)) begin
        codec_dac_data <= tx_shift_r[SW-1];
        tx_shift_r <= {tx_shift_r[SW-2:0], 1'h0};
      end else if (bclk_fall) begin
        codec_dac_data <= 1'h0; // slots past the word carry zeros
      end
    end
  end
endmodule

// ### arpc_monitor.sv
// port assertions for arpc_top: switches, buttons, store full, clock pass-through
// assumes binding into arpc_top and buttons held well past the debounce time
`timescale 1ns/1ps
module arpc_monitor
  import arpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic source_select_switch,
  input wire logic rate_select_bit2,
  input wire logic rate_select_bit1,
  input wire logic rate_select_bit0,
  input wire logic record_button_n,
  input wire logic play_button_n,
  input wire logic pll_clk,
  input wire logic codec_master_clock_pin,
  input wire logic line_input_select,
  input wire arpc_pkg::arpc_rate_type sample_rate,
  input wire logic recording,
  input wire logic playing,
  input wire logic store_full,
  input wire logic play_ready
);
  logic [2:0] rsel;
  // switch code msb first
  assign rsel = {rate_select_bit2, rate_select_bit1, rate_select_bit0};
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // unlisted codes fall back to 96K
  function automatic arpc_rate_type want(logic [2:0] s);
    return (s > 3'h4) ? arpc_rate_96k_type_v : arpc_rate_type'(s);
  endfunction
  AST_MCLK: assert property (codec_master_clock_pin == pll_clk)
    else $error("master clock pin differs from pll clock");
  // six quiet cycles cover the two sync flops and the register
  AST_RATE: assert property ($stable(rsel)[*6] |-> sample_rate == want(rsel))
    else $error("sample rate does not follow switches");
  AST_SRC: assert property ($stable(source_select_switch)[*6] |-> line_input_select == source_select_switch)
    else $error("source select does not follow switch");
  AST_FULL: assert property (recording && store_full |=> !recording)
    else $error("recording went on with store full");
  AST_REC_RISE: assert property ($rose(recording) |-> !record_button_n && $past(record_button_n, 8) == 1'b0)
    else $error("recording started without a held press");
  AST_REC_FALL: assert property ($fell(recording) |-> $past(store_full) || !record_button_n)
    else $error("recording stopped without press or full store");
  AST_PLAY_RISE: assert property ($rose(playing) |-> !play_button_n && $past(play_button_n, 8) == 1'b0)
    else $error("playback started without a held press");
  AST_PLAY_IDLE: assert property (!playing |-> !play_ready)
    else $error("play frame taken while idle");
endmodule
bind arpc_top arpc_monitor mon_u (.*);

// ### arpc_codec_model.sv
// behavioural stereo codec as i2s link master, 48 ns bit clock
// assumes the bench raises run to keep frames coming
`timescale 1ns/1ps
module arpc_codec_model (
  output logic codec_bit_clock,
  output logic codec_frame_clock,
  output logic codec_adc_data,
  input wire logic codec_dac_data,
  input wire logic run,
  output logic [31:0] dac_frame,
  output logic [15:0] n_frames
);
  logic [31:0] tx, rx;
  logic [7:0] k;
  logic lsb, busy;
  // data and frame clock move on the falling edge, dac sampled on the rising
  task automatic slot(logic d, logic f);
    #24 codec_bit_clock = 1'b0;
    codec_adc_data = d;
    codec_frame_clock = f;
    #24 codec_bit_clock = 1'b1;
    rx = {rx[30:0], codec_dac_data};
  endtask
  // clock stands still between bursts; the owed right lsb gets one last clock
  initial begin
    {codec_bit_clock, codec_frame_clock, codec_adc_data, lsb, busy} = 5'h18;
    {k, n_frames, dac_frame, rx} = '0;
    forever begin
      if (!run) begin
        if (busy) slot(lsb, 1'b1);
        if (busy) dac_frame = rx;
        if (busy) n_frames++;
        busy = 1'b0;
        codec_adc_data = ~lsb; // released line shows no stale bit
        wait (run);
      end
      tx = {8'hC3, k, 8'h3C, ~k};
      for (int i = 0; i < 32; i++) begin
        slot(i == 0 ? lsb : tx[32 - i], i > 15);
        if (i == 0 && busy) dac_frame = rx;
        if (i == 0 && busy) n_frames++;
      end
      lsb = tx[0];
      busy = 1'b1;
      k++;
    end
  end
endmodule

// ### arpc_tb.sv
// self-checking bench for arpc_top with a codec model on the serial link
// assumes arpc_codec_model and the bound arpc_monitor are compiled first
`timescale 1ns/1ps
module tb;
  import arpc_pkg::*;
  logic ref_clk, reset, pll_clk, source_select_switch, rate_select_bit2, rate_select_bit1;
  logic rate_select_bit0, record_button_n, play_button_n, codec_master_clock_pin, codec_bit_clock;
  logic codec_frame_clock, codec_adc_data, codec_dac_data, i2c_clock_out, i2c_clock_oe, i2c_clock_in;
  logic i2c_data_out, i2c_data_oe, i2c_data_in, codec_i2c_clock_in, codec_i2c_clock_out;
  logic codec_i2c_clock_oe, codec_i2c_data_in, codec_i2c_data_out, codec_i2c_data_oe;
  logic line_input_select, recording, playing, store_full, rec_valid, rec_ready;
  logic play_last, play_valid, play_ready, run;
  logic [31:0] dac_frame;
  logic [15:0] n_frames;
  arpc_rate_type sample_rate;
  arpc_frame_type rec_data, play_data;
  int failures, n_compared;
  arpc_top dut_u (.*);
  arpc_codec_model codec_u (.*);
  // 200 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // 18.432 MHz pll clock, unrelated in phase
  initial begin
    pll_clk = 1'b0;
    forever #27.127 pll_clk = ~pll_clk;
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic hang();
    failures++;
    finish_test();
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // a press must outlast the 2000-cycle debounce, and so must the release
  task automatic press(bit play);
    @(posedge ref_clk);
    if (play) play_button_n <= 1'b0;
    else record_button_n <= 1'b0;
    cyc(2100);
    if (play) play_button_n <= 1'b1;
    else record_button_n <= 1'b1;
    cyc(2100);
  endtask
  // hold the frame until ready is seen, then drop valid after the taking edge
  task automatic send(logic [31:0] d, logic last);
    int i;
    @(posedge ref_clk);
    {play_data, play_last, play_valid} <= {d, last, 1'b1};
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (play_ready !== 1'b1 && i < 4000);
    if (play_ready !== 1'b1) hang();
    @(posedge ref_clk);
    play_valid <= 1'b0;
  endtask
  task automatic t_switch();
    chk("rate", sample_rate, arpc_rate_96k_type_v);
    chk("recording", recording, 0);
    chk("playing", playing, 0);
    for (int k = 0; k < 64; k++) begin
      @(posedge ref_clk);
      {rate_select_bit2, rate_select_bit1, rate_select_bit0, source_select_switch} <= k[3:0];
      {i2c_clock_out, i2c_clock_oe, i2c_data_out, i2c_data_oe, codec_i2c_clock_in, codec_i2c_data_in} <= k[5:0];
      cyc(8);
      @(negedge ref_clk);
      chk("rate", sample_rate, k[3:1] < 5 ? k[3:1] : 0);
      chk("line", line_input_select, k[0]);
      chk("i2c", {codec_i2c_clock_out, codec_i2c_clock_oe, codec_i2c_data_out, codec_i2c_data_oe,
        i2c_clock_in, i2c_data_in}, k[5:0]);
      chk("mclk", codec_master_clock_pin, pll_clk);
    end
    $display("switch test done");
  endtask
  // fill the record buffer while stalled, then drain it and count
  task automatic t_rec();
    int n;
    run <= 1'b1;
    press(0);
    chk("rec on", recording, 1);
    cyc(3000);
    press(0);
    chk("rec off", recording, 0);
    run <= 1'b0;
    cyc(400);
    rec_ready <= 1'b1;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge ref_clk);
      if (rec_valid === 1'b1) n++;
      if (rec_valid === 1'b1) chk("rec word", rec_data, {8'hC3, rec_data.left[7:0], 8'h3C, ~rec_data.left[7:0]});
    end
    chk("rec depth", n, 16);
    run <= 1'b1;
    press(0);
    store_full <= 1'b1;
    cyc(2);
    chk("rec full", recording, 0);
    store_full <= 1'b0;
    $display("record test done");
  endtask
  task automatic t_play();
    logic [31:0] got[$];
    logic [15:0] seen;
    int i;
    press(1);
    chk("play on", playing, 1);
    send(32'h81C37E24, 1'b0);
    press(1);
    chk("play off", playing, 0);
    press(1);
    seen = n_frames;
    for (int k = 0; k < 4; k++) send(32'h81C37E24 + k, k == 3);
    for (i = 0; i < 8000 && !(got.size() > 3 && playing === 1'b0); i++) begin
      @(negedge ref_clk);
      if (n_frames != seen && dac_frame != 0) got.push_back(dac_frame);
      seen = n_frames;
    end
    if (i == 8000) hang();
    chk("play end", playing, 0);
    for (int k = 0; k < 4; k++) chk("dac", got[k], 32'h81C37E24 + k);
    run <= 1'b0;
    $display("play test done");
  endtask
  initial begin
    {reset, source_select_switch, rate_select_bit2, rate_select_bit1, rate_select_bit0} = 5'h10;
    {record_button_n, play_button_n, i2c_clock_out, i2c_clock_oe, i2c_data_out, i2c_data_oe} = 6'h30;
    {codec_i2c_clock_in, codec_i2c_data_in, store_full, rec_ready, play_last, play_valid, run} = 7'h00;
    play_data = '0;
    failures = 0;
    n_compared = 0;
    cyc(10);
    reset <= 1'b0;
    cyc(2);
    t_switch();
    t_rec();
    t_play();
    finish_test();
  end
endmodule
